// ===== verilog/handshaked_parallel_port.sv
/*
  Three-port 8-bit parallel interface with handshake lines on port C,
  reached over AXI4-Lite, with sticky status and one level interrupt.
  Pins are taken as synchronous to clk_i; the bench resolves the
  three-signal pins into wires.
*/
module handshaked_parallel_port (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic [7:0] first_data_port_i,
  output logic [7:0] first_data_port_o,
  output logic [7:0] first_data_port_oe_o,
  input wire logic [7:0] second_data_port_i,
  output logic [7:0] second_data_port_o,
  output logic [7:0] second_data_port_oe_o,
  input wire logic [7:0] aux_port_pins_i,
  output logic [7:0] aux_port_pins_o,
  output logic [7:0] aux_port_pins_oe_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register state

  logic [5:0] ctrl_reg;
  logic [7:0] out_a_reg, out_b_reg, out_c_reg;
  logic [23:0] dir_reg;
  logic [7:0] in_a_reg, in_b_reg;
  logic [ppi_pkg::ST_W-1:0] stat_reg, ien_reg;
  logic ibf_a_reg, ibf_b_reg, obf_n_a_reg, obf_n_b_reg;
  logic stb_a_q_reg, stb_b_q_reg, ack_a_q_reg, ack_b_q_reg;
  ppi_pkg::port_mode_t mode_a, mode_b;
  logic sren_a, sren_b;

  assign mode_a = ppi_pkg::port_mode_t'(ctrl_reg[ppi_pkg::CTRL_MODE_A_LSB
                  +: 2]);
  // Bidirectional is port A only; B falls back to handshaked output
  assign mode_b = (ctrl_reg[ppi_pkg::CTRL_MODE_B_LSB +: 2] ==
                   ppi_pkg::MODE_BIDIR) ? ppi_pkg::MODE_HS_OUT :
                  ppi_pkg::port_mode_t'(ctrl_reg[ppi_pkg::CTRL_MODE_B_LSB
                  +: 2]);
  assign sren_a = ctrl_reg[ppi_pkg::CTRL_SREN_A];
  assign sren_b = ctrl_reg[ppi_pkg::CTRL_SREN_B];

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic aw_held_reg, w_held_reg;
  ppi_pkg::wr_req_t wr_reg;
  logic wr_go;
  assign wr_go = aw_held_reg && w_held_reg && !bvalid_o;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_reg <= '0;
      awready_o <= 1'b0;
      wready_o <= 1'b0;
    end else begin
      awready_o <= !aw_held_reg && !(awvalid_i && awready_o);
      wready_o <= !w_held_reg && !(wvalid_i && wready_o);
      if (awvalid_i && awready_o) begin
        aw_held_reg <= 1'b1;
        wr_reg.addr <= awaddr_i;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_held_reg <= 1'b1;
        wr_reg.data <= wdata_i;
        wr_reg.strb <= wstrb_i;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  logic wr_hit;
  always_comb begin
    case (wr_reg.addr)
      ppi_pkg::OFS_CTRL, ppi_pkg::OFS_PA, ppi_pkg::OFS_PB, ppi_pkg::OFS_PC,
      ppi_pkg::OFS_DIR, ppi_pkg::OFS_STAT, ppi_pkg::OFS_IEN,
      ppi_pkg::OFS_ICLR, ppi_pkg::OFS_HS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_o <= 1'b0;
      bresp_o <= ppi_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_o <= 1'b1;
      bresp_o <= wr_hit ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end
  logic we_ctrl, we_pa, we_pb, we_pc, we_ien, we_iclr;
  assign we_ctrl = wr_go && wr_reg.addr == ppi_pkg::OFS_CTRL && wr_reg.strb[0];
  assign we_pa = wr_go && wr_reg.addr == ppi_pkg::OFS_PA && wr_reg.strb[0];
  assign we_pb = wr_go && wr_reg.addr == ppi_pkg::OFS_PB && wr_reg.strb[0];
  assign we_pc = wr_go && wr_reg.addr == ppi_pkg::OFS_PC && wr_reg.strb[0];
  assign we_ien = wr_go && wr_reg.addr == ppi_pkg::OFS_IEN && wr_reg.strb[0];
  assign we_iclr = wr_go && wr_reg.addr == ppi_pkg::OFS_ICLR && wr_reg.strb[0];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= ppi_pkg::CTRL_RESET;
      out_a_reg <= 8'h00;
      out_b_reg <= 8'h00;
      out_c_reg <= 8'h00;
      dir_reg <= 24'h000000;
      ien_reg <= '0;
    end else begin
      if (we_ctrl) ctrl_reg <= wr_reg.data[5:0];
      if (we_pa) out_a_reg <= wr_reg.data[7:0];
      if (we_pb) out_b_reg <= wr_reg.data[7:0];
      if (we_pc) out_c_reg <= wr_reg.data[7:0];
      if (we_ien) ien_reg <= wr_reg.data[ppi_pkg::ST_W-1:0];
      if (wr_go && wr_reg.addr == ppi_pkg::OFS_DIR) begin
        for (int i = 0; i < 3; i++) begin
          if (wr_reg.strb[i]) dir_reg[i*8 +: 8] <= wr_reg.data[i*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic rd_a_fire, rd_b_fire, rd_fire;
  assign rd_fire = arvalid_i && arready_o;
  // Reading a data port is the internal host read strobe
  assign rd_a_fire = rd_fire && araddr_i == ppi_pkg::OFS_PA;
  assign rd_b_fire = rd_fire && araddr_i == ppi_pkg::OFS_PB;
  logic [31:0] rd_data;
  logic rd_hit;
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (araddr_i)
      ppi_pkg::OFS_CTRL: rd_data[5:0] = ctrl_reg;
      ppi_pkg::OFS_PA: rd_data[7:0] = (mode_a == ppi_pkg::MODE_PLAIN) ?
                                      first_data_port_i : in_a_reg;
      ppi_pkg::OFS_PB: rd_data[7:0] = (mode_b == ppi_pkg::MODE_PLAIN) ?
                                      second_data_port_i : in_b_reg;
      ppi_pkg::OFS_PC: rd_data[7:0] = aux_port_pins_i;
      ppi_pkg::OFS_DIR: rd_data[23:0] = dir_reg;
      ppi_pkg::OFS_STAT: rd_data[ppi_pkg::ST_W-1:0] = stat_reg;
      ppi_pkg::OFS_IEN: rd_data[ppi_pkg::ST_W-1:0] = ien_reg;
      ppi_pkg::OFS_ICLR: rd_data = 32'h00000000;
      ppi_pkg::OFS_HS: rd_data[3:0] = {obf_n_b_reg, ibf_b_reg,
                                       obf_n_a_reg, ibf_a_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h00000000;
      rresp_o <= ppi_pkg::RESP_OKAY;
    end else begin
      arready_o <= !rvalid_o && !rd_fire;
      if (rd_fire) begin
        rvalid_o <= 1'b1;
        rdata_o <= rd_data;
        rresp_o <= rd_hit ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Handshake engine

  logic in_a_en, out_a_en, in_b_en, out_b_en;
  assign in_a_en = mode_a == ppi_pkg::MODE_HS_IN ||
                   mode_a == ppi_pkg::MODE_BIDIR;
  assign out_a_en = mode_a == ppi_pkg::MODE_HS_OUT ||
                    mode_a == ppi_pkg::MODE_BIDIR;
  assign in_b_en = mode_b == ppi_pkg::MODE_HS_IN;
  assign out_b_en = mode_b == ppi_pkg::MODE_HS_OUT;
  logic stb_a_n, stb_b_n, ack_a_n, ack_b_n;
  assign stb_a_n = aux_port_pins_i[ppi_pkg::PC_STB_A];
  assign stb_b_n = aux_port_pins_i[ppi_pkg::PC_STB_B];
  assign ack_a_n = aux_port_pins_i[ppi_pkg::PC_ACK_A];
  assign ack_b_n = aux_port_pins_i[ppi_pkg::PC_ACK_B];
  logic cap_a, cap_b, acc_a, acc_b;
  assign cap_a = in_a_en && !stb_a_n && stb_a_q_reg;
  assign cap_b = in_b_en && !stb_b_n && stb_b_q_reg;
  assign acc_a = out_a_en && !ack_a_n && ack_a_q_reg && !obf_n_a_reg;
  assign acc_b = out_b_en && !ack_b_n && ack_b_q_reg && !obf_n_b_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stb_a_q_reg <= 1'b1;
      stb_b_q_reg <= 1'b1;
      ack_a_q_reg <= 1'b1;
      ack_b_q_reg <= 1'b1;
    end else begin
      stb_a_q_reg <= stb_a_n;
      stb_b_q_reg <= stb_b_n;
      ack_a_q_reg <= ack_a_n;
      ack_b_q_reg <= ack_b_n;
    end
  end
  // Latch follows pins while strobe is low
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_a_reg <= 8'h00;
      in_b_reg <= 8'h00;
    end else begin
      if (in_a_en && !stb_a_n) in_a_reg <= first_data_port_i;
      if (in_b_en && !stb_b_n) in_b_reg <= second_data_port_i;
    end
  end
  // Set wins over host-read clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ibf_a_reg <= 1'b0;
      ibf_b_reg <= 1'b0;
    end else begin
      if (!in_a_en) ibf_a_reg <= 1'b0;
      else if (cap_a) ibf_a_reg <= 1'b1;
      else if (rd_a_fire) ibf_a_reg <= 1'b0;
      if (!in_b_en) ibf_b_reg <= 1'b0;
      else if (cap_b) ibf_b_reg <= 1'b1;
      else if (rd_b_fire) ibf_b_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      obf_n_a_reg <= 1'b1;
      obf_n_b_reg <= 1'b1;
    end else begin
      if (!out_a_en) obf_n_a_reg <= 1'b1;
      else if (we_pa) obf_n_a_reg <= 1'b0;
      else if (acc_a) obf_n_a_reg <= 1'b1;
      if (!out_b_en) obf_n_b_reg <= 1'b1;
      else if (we_pb) obf_n_b_reg <= 1'b0;
      else if (acc_b) obf_n_b_reg <= 1'b1;
    end
  end
  // Sticky events; new event beats a clear in the same cycle
  logic [ppi_pkg::ST_W-1:0] ev;
  assign ev = {acc_b, cap_b, acc_a, cap_a};
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= ev | (stat_reg & ~(we_iclr ?
                  wr_reg.data[ppi_pkg::ST_W-1:0] : '0));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive

  logic srq_a, srq_b;
  // Request while input full, or output taken and awaiting refill
  assign srq_a = sren_a && ((in_a_en && ibf_a_reg) ||
                 (out_a_en && obf_n_a_reg && stat_reg[ppi_pkg::ST_OUT_A]));
  assign srq_b = sren_b && ((in_b_en && ibf_b_reg) ||
                 (out_b_en && obf_n_b_reg && stat_reg[ppi_pkg::ST_OUT_B]));
  ppi_pkg::pins_out_t pc_n;
  always_comb begin
    // Plain I/O by default, per-bit direction from dir_reg[23:16] on every bit no handshake line claims
    pc_n.out = out_c_reg;
    pc_n.oe = dir_reg[23:16];
    if (in_a_en) begin
      pc_n.out[ppi_pkg::PC_IBF_A] = ibf_a_reg;
      pc_n.oe[ppi_pkg::PC_IBF_A] = 1'b1;
      pc_n.oe[ppi_pkg::PC_STB_A] = 1'b0;
    end
    if (out_a_en) begin
      pc_n.out[ppi_pkg::PC_OBF_A] = obf_n_a_reg;
      pc_n.oe[ppi_pkg::PC_OBF_A] = 1'b1;
      pc_n.oe[ppi_pkg::PC_ACK_A] = 1'b0;
    end
    if (in_a_en || out_a_en) begin
      pc_n.out[ppi_pkg::PC_SRQ_A] = srq_a;
      pc_n.oe[ppi_pkg::PC_SRQ_A] = 1'b1;
    end
    if (in_b_en) begin
      pc_n.out[ppi_pkg::PC_IBF_B] = ibf_b_reg;
      pc_n.oe[ppi_pkg::PC_IBF_B] = 1'b1;
      pc_n.oe[ppi_pkg::PC_STB_B] = 1'b0;
    end
    if (out_b_en) begin
      pc_n.out[ppi_pkg::PC_OBF_B] = obf_n_b_reg;
      pc_n.oe[ppi_pkg::PC_OBF_B] = 1'b1;
      pc_n.oe[ppi_pkg::PC_ACK_B] = 1'b0;
    end
    if (in_b_en || out_b_en) begin
      pc_n.out[ppi_pkg::PC_SRQ_B] = srq_b;
      pc_n.oe[ppi_pkg::PC_SRQ_B] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aux_port_pins_o <= 8'h00;
      aux_port_pins_oe_o <= 8'h00;
      first_data_port_o <= 8'h00;
      first_data_port_oe_o <= 8'h00;
      second_data_port_o <= 8'h00;
      second_data_port_oe_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      aux_port_pins_o <= pc_n.out;
      aux_port_pins_oe_o <= pc_n.oe;
      // Data words only on ports A and B
      first_data_port_o <= out_a_reg;
      second_data_port_o <= out_b_reg;
      case (mode_a)
        ppi_pkg::MODE_PLAIN: first_data_port_oe_o <= dir_reg[7:0];
        ppi_pkg::MODE_HS_IN: first_data_port_oe_o <= 8'h00;
        ppi_pkg::MODE_HS_OUT: first_data_port_oe_o <= 8'hff;
        // Bidirectional drives only while acknowledge held low
        ppi_pkg::MODE_BIDIR: first_data_port_oe_o <= {8{!ack_a_n}};
        default: first_data_port_oe_o <= 8'h00;
      endcase
      case (mode_b)
        ppi_pkg::MODE_PLAIN: second_data_port_oe_o <= dir_reg[15:8];
        ppi_pkg::MODE_HS_OUT: second_data_port_oe_o <= 8'hff;
        default: second_data_port_oe_o <= 8'h00;
      endcase
      irq_o <= |(stat_reg & ien_reg);
    end
  end

endmodule

// ===== verilog/ppi_pkg.sv
/*
  Package for the handshaked parallel port: register offsets, mode codes,
  port C bit positions, status/interrupt layout and bus types.
  Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
*/
package ppi_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PA = 8'h04;
  localparam logic [7:0] OFS_PB = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_DIR = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_IEN = 8'h18;
  localparam logic [7:0] OFS_ICLR = 8'h1c;
  localparam logic [7:0] OFS_HS = 8'h20;

  // Mode encoding, per data port
  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_HS_IN = 2'b01,
    MODE_HS_OUT = 2'b10,
    MODE_BIDIR = 2'b11
  } port_mode_t;

  // Control register fields
  localparam int unsigned CTRL_MODE_A_LSB = 0;
  localparam int unsigned CTRL_MODE_B_LSB = 2;
  localparam int unsigned CTRL_SREN_A = 4;
  localparam int unsigned CTRL_SREN_B = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Port C pin positions
  localparam int unsigned PC_OBF_A = 7;
  localparam int unsigned PC_ACK_A = 6;
  localparam int unsigned PC_IBF_A = 5;
  localparam int unsigned PC_STB_A = 4;
  localparam int unsigned PC_SRQ_A = 3;
  localparam int unsigned PC_STB_B = 2;
  localparam int unsigned PC_ACK_B = 2;
  localparam int unsigned PC_IBF_B = 1;
  localparam int unsigned PC_OBF_B = 1;
  localparam int unsigned PC_SRQ_B = 0;

  // Sticky status bit positions
  localparam int unsigned ST_IN_A = 0;
  localparam int unsigned ST_OUT_A = 1;
  localparam int unsigned ST_IN_B = 2;
  localparam int unsigned ST_OUT_B = 3;
  localparam int unsigned ST_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } wr_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pins_out_t;

endpackage

// ===== test/ppi_sva.sv
/*
  Checker for the handshaked parallel port: bus answer holding and
  port C handshake timing. Sees only top-level ports; one clock domain.
*/
module ppi_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic arready_o,
  input wire logic [7:0] aux_port_pins_i,
  input wire logic [7:0] aux_port_pins_o,
  input wire logic [7:0] aux_port_pins_oe_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pi;
  logic [7:0] po;
  logic [7:0] oe;
  logic input_latch_full;
  logic wr_seen;
  assign pi = aux_port_pins_i;
  assign po = aux_port_pins_o;
  assign oe = aux_port_pins_oe_o;
  assign input_latch_full = po[5] & oe[5];
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////////////////////////////////////////////
  AST_IBF_AFTER_STB: assert property (
    $rose(input_latch_full) |-> !$past(pi[4], 2)) else $error("full without strobe");
  AST_IBF_HOLD: assert property (
    input_latch_full && !rvalid_o && !$past(rvalid_o) && !$past(rvalid_o, 2) |=> input_latch_full)
    else $error("input full dropped without read");
  AST_OBF_AFTER_WRITE: assert property (
    $fell(po[7]) && oe[7] |-> $past(bvalid_o) || $past(bvalid_o, 2) ||
    $past(bvalid_o, 3) || $past(bvalid_o, 4))
    else $error("output full fell without write");
  AST_OBF_RETURN: assert property (
    $fell(pi[6]) && oe[7] && !po[7] |-> ##[1:4] po[7])
    else $error("output full not restored");
  AST_SRQ_NEEDS_FULL: assert property (
    oe[3] && po[3] |-> po[5] || po[7] || $past(po[5]) || $past(po[7]))
    else $error("service request without transfer");
  AST_IRQ_FALL: assert property (
    $fell(irq_o) |-> $past(bvalid_o) || $past(bvalid_o, 2) ||
    $past(bvalid_o, 3) || $past(bvalid_o, 4))
    else $error("interrupt fell without write");
  AST_BVALID_HOLD: assert property (
    bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response not held");
  AST_RVALID_HOLD: assert property (
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data not held");
  AST_AR_BLOCK: assert property (
    rvalid_o |-> !arready_o) else $error("address taken during answer");
  cover property ($rose(input_latch_full));
  cover property ($fell(po[7]) && oe[7]);
  cover property ($rose(irq_o));
endmodule

bind handshaked_parallel_port ppi_checker ppi_checker_i (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .bvalid_o(bvalid_o),
  .bready_i(bready_i), .bresp_o(bresp_o), .rvalid_o(rvalid_o),
  .rready_i(rready_i), .rdata_o(rdata_o), .arready_o(arready_o),
  .aux_port_pins_i(aux_port_pins_i), .aux_port_pins_o(aux_port_pins_o),
  .aux_port_pins_oe_o(aux_port_pins_oe_o), .irq_o(irq_o)
);

// ===== test/periph_model.sv
/*
  Peripheral beside the parallel port: strobes bytes in, acknowledges
  bytes out on port A only. Takes the design's pin outputs and resolves all pin inputs.
*/
module periph_model (
  input wire logic clk_i,
  input wire logic [3:0] ack_delay_i,
  input wire logic [7:0] pa_o_i,
  input wire logic [7:0] pa_oe_i,
  input wire logic [7:0] pb_o_i,
  input wire logic [7:0] pb_oe_i,
  input wire logic [7:0] pc_o_i,
  input wire logic [7:0] pc_oe_i,
  output logic [7:0] pa_i_o,
  output logic [7:0] pb_i_o,
  output logic [7:0] pc_i_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pa_drv = 8'h00;
  logic [7:0] pb_drv = 8'h00;
  logic [7:0] got_a = 8'h00;
  logic [7:0] own_c;
  logic pa_on = 1'b0;
  logic pb_on = 1'b0;
  logic stb_a_n = 1'b1;
  logic stb_b_n = 1'b1;
  logic ack_a_n = 1'b1;
  logic [3:0] waited = 4'h0;
  // Released lines show the model's byte while it drives, else the inverse of the design's current output value
  assign pa_i_o = (pa_oe_i & pa_o_i) |
    (~pa_oe_i & (pa_on ? pa_drv : ~pa_o_i));
  assign pb_i_o = (pb_oe_i & pb_o_i) |
    (~pb_oe_i & (pb_on ? pb_drv : ~pb_o_i));
  assign own_c = {~pc_o_i[7], ack_a_n, ~pc_o_i[5], stb_a_n,
    ~pc_o_i[3], stb_b_n, ~pc_o_i[1:0]};
  assign pc_i_o = (pc_oe_i & pc_o_i) | (~pc_oe_i & own_c);
  //////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (pc_oe_i[7] && !pc_o_i[7]) begin
      if (ack_a_n && waited >= ack_delay_i) begin
        ack_a_n <= 1'b0;
        got_a <= pa_i_o;
      end
      waited <= waited + 4'h1;
    end else begin
      ack_a_n <= 1'b1;
      waited <= 4'h0;
    end
  end
  task automatic push(input logic port_b, input logic [7:0] d,
                      input int hold);
    @(posedge clk_i);
    pa_drv <= d;
    pb_drv <= d;
    pa_on <= !port_b;
    pb_on <= port_b;
    @(posedge clk_i);
    stb_a_n <= port_b;
    stb_b_n <= !port_b;
    repeat (hold) @(posedge clk_i);
    stb_a_n <= 1'b1;
    stb_b_n <= 1'b1;
    @(posedge clk_i);
    pa_on <= 1'b0;
    pb_on <= 1'b0;
  endtask
endmodule

// ===== test/tb_handshaked_parallel_port.sv
/*
  Bench for the handshaked parallel port: AXI4-Lite tasks and scenarios.
  Needs the package, the peripheral model and the bound checker.
*/
module tb_handshaked_parallel_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [7:0] pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, pc_i, pc_o, pc_oe;
  logic [3:0] ack_delay = 4'h0;
  logic [7:0] ctrl_tab [4] = '{8'h00, 8'h35, 8'h3a, 8'h33};
  logic [7:0] oe_tab [4] = '{8'h00, 8'h2b, 8'h8b, 8'ha8};
  logic [7:0] lvl_tab [4] = '{8'h00, 8'h00, 8'h82, 8'h80};
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  handshaked_parallel_port handshaked_parallel_port_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .awaddr_i(awaddr),
    .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata),
    .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
    .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
    .rready_i(rready), .first_data_port_i(pa_i), .first_data_port_o(pa_o),
    .first_data_port_oe_o(pa_oe), .second_data_port_i(pb_i),
    .second_data_port_o(pb_o), .second_data_port_oe_o(pb_oe),
    .aux_port_pins_i(pc_i), .aux_port_pins_o(pc_o),
    .aux_port_pins_oe_o(pc_oe), .irq_o(irq));
  periph_model periph_i (
    .clk_i(clk_i), .ack_delay_i(ack_delay), .pa_o_i(pa_o),
    .pa_oe_i(pa_oe), .pb_o_i(pb_o), .pb_oe_i(pb_oe), .pc_o_i(pc_o),
    .pc_oe_i(pc_oe), .pa_i_o(pa_i), .pb_i_o(pb_i), .pc_i_o(pc_i));
  //////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wc(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = ppi_pkg::RESP_OKAY);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_i);
    bready <= 1'b0;
    check("bresp", bresp, e);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x,
                    input string nm, input logic [1:0] e = 2'b00);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    rready <= 1'b0;
    check(nm, rdata, x);
    check("rresp", rresp, e);
  endtask
  task automatic wait_pc(input int b, input logic v);
    int n;
    n = 0;
    while (pc_o[b] !== v && n < 20) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    check("pc_oe", pc_oe, 8'h00);
    rc(ppi_pkg::OFS_CTRL, 32'h0, "ctrl");
    rc(8'h40, 32'h0, "unmapped", ppi_pkg::RESP_SLVERR);
    wc(8'h40, 32'h1, ppi_pkg::RESP_SLVERR);
    wc(ppi_pkg::OFS_DIR, 32'h000fffff);
    wc(ppi_pkg::OFS_PA, 32'ha5);
    wc(ppi_pkg::OFS_PB, 32'h3c);
    wc(ppi_pkg::OFS_PC, 32'h05);
    repeat (3) @(posedge clk_i);
    check("pa_o", pa_o, 8'ha5);
    check("pc_oe", pc_oe, 8'h0f);
    rc(ppi_pkg::OFS_PB, 32'h3c, "pb");
    rc(ppi_pkg::OFS_PC, 32'hf5, "pc");
    wc(ppi_pkg::OFS_DIR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wc(ppi_pkg::OFS_CTRL, {24'h0, ctrl_tab[i]});
      repeat (3) @(posedge clk_i);
      check("pc map", pc_oe, oe_tab[i]);
      check("idle", pc_o & pc_oe, lvl_tab[i]);
    end
    wc(ppi_pkg::OFS_IEN, 32'h1);
    wc(ppi_pkg::OFS_CTRL, 32'h11);
    repeat (3) @(posedge clk_i);
    check("pa_oe", pa_oe, 8'h00);
    periph_i.push(1'b0, 8'h5a, 2);
    wait_pc(5, 1'b1);
    check("ibf a", pc_o[5], 1'b1);
    check("srq a", pc_o[3], 1'b1);
    check("irq", irq, 1'b1);
    rc(ppi_pkg::OFS_HS, 32'hb, "hs");
    rc(ppi_pkg::OFS_PA, 32'h5a, "pa in");
    repeat (3) @(posedge clk_i);
    check("ibf a", pc_o[5], 1'b0);
    check("srq a", pc_o[3], 1'b0);
    rc(ppi_pkg::OFS_STAT, 32'h1, "stat");
    wc(ppi_pkg::OFS_ICLR, 32'h1);
    wc(ppi_pkg::OFS_IEN, 32'h0);
    wc(ppi_pkg::OFS_CTRL, 32'h01);
    periph_i.push(1'b0, 8'hc3, 1);
    wait_pc(5, 1'b1);
    check("srq off", pc_o[3], 1'b0);
    check("irq off", irq, 1'b0);
    wc(ppi_pkg::OFS_IEN, 32'h1);
    repeat (3) @(posedge clk_i);
    check("irq on", irq, 1'b1);
    rc(ppi_pkg::OFS_PA, 32'hc3, "pa in");
    wc(ppi_pkg::OFS_ICLR, 32'h1);
    repeat (3) @(posedge clk_i);
    check("irq clr", irq, 1'b0);
    wc(ppi_pkg::OFS_CTRL, 32'h24);
    periph_i.push(1'b1, 8'h69, 1);
    wait_pc(1, 1'b1);
    check("ibf b", pc_o[1], 1'b1);
    check("srq b", pc_o[0], 1'b1);
    rc(ppi_pkg::OFS_PB, 32'h69, "pb in");
    repeat (3) @(posedge clk_i);
    check("ibf b", pc_o[1], 1'b0);
    wc(ppi_pkg::OFS_ICLR, 32'hf);
    wc(ppi_pkg::OFS_IEN, 32'h2);
    ack_delay <= 4'h3;
    wc(ppi_pkg::OFS_CTRL, 32'h12);
    wc(ppi_pkg::OFS_PA, 32'h96);
    wait_pc(7, 1'b0);
    check("obf a", pc_o[7], 1'b0);
    check("pa_o", pa_o & pa_oe, 8'h96);
    wait_pc(7, 1'b1);
    check("got", periph_i.got_a, 8'h96);
    repeat (3) @(posedge clk_i);
    check("srq a", pc_o[3], 1'b1);
    check("irq", irq, 1'b1);
    rc(ppi_pkg::OFS_STAT, 32'h2, "stat");
    ack_delay <= 4'h0;
    wc(ppi_pkg::OFS_PA, 32'h69);
    wait_pc(7, 1'b0);
    check("srq a", pc_o[3], 1'b0);
    wait_pc(7, 1'b1);
    check("got", periph_i.got_a, 8'h69);
    end_sim();
  end
endmodule
